//--- design/ddr_channel_pin_interface.sv
// DDR channel pin interface: command clock, command pins, clock enables,
// write burst out of a word FIFO and read capture on memory strobes.
// Assumes a 250 MHz clock, user logic on that clock, memory on the pins.
//
// Overview of operation
// RL1: Drive command clock pairs, complement exact inverse; memory samples on true rise.
// RL2: Six command clock pairs per channel, three for each module.
// RL3: One active-low select per row, four, changing on command clock rise.
// RL4: Row and column addresses share one 13-bit multiplexed address bus.
// RL5: Two-bit bank select, set with the address, picks the bank.
// RL6: Command is row, column, write strobe levels qualified by row select.
// RL7: Data moves over a 64-bit two-way bus.
// RL8: On writes each strobe transition sits centred in its data window.
// RL9: On reads strobes arrive edge aligned; capture data from those strobes.
// RL10: Strobe n times byte n; strobe 8 times the check byte.
// RL11: Clock enables held low during power-up initialisation.
// RL12: Clock enables drop all rows into self-refresh on suspend, raise on resume.
// RL13: Idle rows may have their clock enable dropped for power-down.
// RL14: One clock enable per row, four, changing on command clock rise.
// RL15: An 8-bit check byte moves at double rate with its own strobe.
// RL16: Data and check bits move on both strobe edges, 72 bits per edge.
`timescale 1ns/1ns

module word_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 16,
  localparam int AW = $clog2(DEPTH)
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic push;
  logic pop;

  assign level = wr_ptr_q - rd_ptr_q;
  assign in_ready = level != (AW+1)'(DEPTH);
  assign out_valid = level != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= '0;
    end else if (push) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_ptr_q <= '0;
    end else if (pop) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end
endmodule : word_fifo

module ddr_channel_pin_interface #(
  parameter int INIT_CYC = ddr_pin_pkg::INIT_CYC
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input ddr_pin_pkg::cmd_t cmd_code,
  input wire logic [1:0] cmd_row,
  input wire logic [ddr_pin_pkg::BANK_W-1:0] cmd_bank,
  input wire logic [ddr_pin_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [ddr_pin_pkg::DATA_W-1:0] wr_data,
  input wire logic [ddr_pin_pkg::ECC_W-1:0] wr_ecc,
  output logic rd_valid,
  output logic [ddr_pin_pkg::DATA_W-1:0] rd_data,
  output logic [ddr_pin_pkg::ECC_W-1:0] rd_ecc,
  input wire logic suspend_req,
  input wire logic [ddr_pin_pkg::ROWS-1:0] idle_rows,
  output logic init_done,
  output logic in_self_refresh,
  output logic [ddr_pin_pkg::CLK_PAIRS-1:0] cmd_clock_pair_p,
  output logic [ddr_pin_pkg::CLK_PAIRS-1:0] cmd_clock_pair_n,
  output logic [ddr_pin_pkg::ROWS-1:0] row_select_n,
  output logic [ddr_pin_pkg::ADDR_W-1:0] mem_addr_mux,
  output logic [ddr_pin_pkg::BANK_W-1:0] bank_select,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic write_strobe_n,
  output logic [ddr_pin_pkg::ROWS-1:0] row_clock_enable,
  input wire logic [ddr_pin_pkg::DATA_W-1:0] mem_data_lines_i,
  output logic [ddr_pin_pkg::DATA_W-1:0] mem_data_lines_o,
  output logic mem_data_lines_oe,
  input wire logic [ddr_pin_pkg::ECC_W-1:0] ecc_check_byte_i,
  output logic [ddr_pin_pkg::ECC_W-1:0] ecc_check_byte_o,
  output logic ecc_check_byte_oe,
  input wire logic [ddr_pin_pkg::LANES-1:0] byte_data_strobe_i,
  output logic [ddr_pin_pkg::LANES-1:0] byte_data_strobe_o,
  output logic [ddr_pin_pkg::LANES-1:0] byte_data_strobe_oe
);
  typedef enum logic [2:0] {st_init, st_idle, st_write, st_read, st_sref} state_t;

  state_t state_q;
  logic [3:0] phase_q;
  logic clk_q;
  logic slot;
  logic mid;
  logic accept;
  logic [15:0] init_cnt_q;
  logic init_done_q;
  logic [2:0] stb_q;
  logic [2:0] stb_enc;
  logic [2:0] beat_q;
  logic load;
  logic pop;
  logic dq_oe_q;
  logic dqs_q;
  logic [ddr_pin_pkg::WORD_W-1:0] wr_word_q;
  logic [ddr_pin_pkg::WORD_W-1:0] fifo_out;
  logic fifo_valid;
  logic [4:0] fifo_level;
  logic [ddr_pin_pkg::WORD_W-1:0] cap_bus;
  logic [ddr_pin_pkg::LANES-1:0] got_bus;
  logic word_done;
  logic [2:0] rd_count_q;
  logic [7:0] rd_wait_q;
  logic rd_valid_q;
  logic [ddr_pin_pkg::WORD_W-1:0] rd_word_q;

  // Command clock divider
  assign slot = phase_q == ddr_pin_pkg::PH_LAST;
  assign mid = phase_q == ddr_pin_pkg::PH_HALF_END;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= '0;
    end else if (slot) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_q + 4'h1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      clk_q <= 1'b0;
    end else if (slot) begin
      clk_q <= 1'b1;
    end else if (mid) begin
      clk_q <= 1'b0;
    end
  end

  assign cmd_clock_pair_p = {ddr_pin_pkg::CLK_PAIRS{clk_q}}; // RL2
  assign cmd_clock_pair_n = {ddr_pin_pkg::CLK_PAIRS{~clk_q}}; // RL1

  // Power-up hold
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      init_cnt_q <= '0;
      init_done_q <= 1'b0;
    end else if (!init_done_q) begin
      init_cnt_q <= init_cnt_q + 16'h1;
      init_done_q <= init_cnt_q == 16'(INIT_CYC - 1);
    end
  end

  // Command acceptance, only at a command clock rise
  assign cmd_ready = state_q == st_idle && slot && !suspend_req &&
                     (cmd_code != ddr_pin_pkg::cmd_write || fifo_level >= 5'(ddr_pin_pkg::BURST_BEATS));
  assign accept = cmd_valid && cmd_ready;

  always_comb begin
    case (cmd_code)
      ddr_pin_pkg::cmd_activate: stb_enc = ddr_pin_pkg::STB_ACT;
      ddr_pin_pkg::cmd_read: stb_enc = ddr_pin_pkg::STB_RD;
      ddr_pin_pkg::cmd_write: stb_enc = ddr_pin_pkg::STB_WR;
      ddr_pin_pkg::cmd_precharge: stb_enc = ddr_pin_pkg::STB_PRE;
      ddr_pin_pkg::cmd_refresh: stb_enc = ddr_pin_pkg::STB_REF;
      ddr_pin_pkg::cmd_mode_set: stb_enc = ddr_pin_pkg::STB_MRS;
      default: stb_enc = ddr_pin_pkg::STB_NOP;
    endcase
  end

  // Command pins, one command clock period per command
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      row_select_n <= ddr_pin_pkg::ROWSEL_NONE;
      stb_q <= ddr_pin_pkg::STB_NOP;
      mem_addr_mux <= '0;
      bank_select <= '0;
    end else if (slot) begin // RL3
      if (accept) begin
        row_select_n <= ~(4'h1 << cmd_row); // RL6
        stb_q <= stb_enc; // RL6
        mem_addr_mux <= cmd_addr; // RL4
        bank_select <= cmd_bank; // RL5
      end else if (state_q == st_idle && suspend_req) begin
        row_select_n <= ~ddr_pin_pkg::ROWSEL_NONE; // RL12
        stb_q <= ddr_pin_pkg::STB_REF;
      end else begin
        row_select_n <= ddr_pin_pkg::ROWSEL_NONE;
        stb_q <= ddr_pin_pkg::STB_NOP;
      end
    end
  end

  assign row_strobe_n = stb_q[2];
  assign column_strobe_n = stb_q[1];
  assign write_strobe_n = stb_q[0];

  // Clock enables per row
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      row_clock_enable <= ddr_pin_pkg::CKE_OFF; // RL11
    end else if (slot) begin // RL14
      case (state_q)
        st_init: begin
          if (init_done_q) begin
            row_clock_enable <= ddr_pin_pkg::CKE_ON; // RL11
          end
        end
        st_idle: begin
          if (suspend_req) begin
            row_clock_enable <= ddr_pin_pkg::CKE_OFF; // RL12
          end else begin
            row_clock_enable <= ~idle_rows; // RL13
          end
        end
        st_sref: begin
          if (!suspend_req) begin
            row_clock_enable <= ddr_pin_pkg::CKE_ON; // RL12
          end
        end
        default: begin
          row_clock_enable <= row_clock_enable;
        end
      endcase
    end
  end

  // Channel sequencing
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= st_init;
    end else begin
      case (state_q)
        st_init: begin
          if (slot && init_done_q) begin
            state_q <= st_idle;
          end
        end
        st_idle: begin
          if (accept && cmd_code == ddr_pin_pkg::cmd_write) begin
            state_q <= st_write;
          end else if (accept && cmd_code == ddr_pin_pkg::cmd_read) begin
            state_q <= st_read;
          end else if (slot && suspend_req) begin
            state_q <= st_sref;
          end
        end
        st_write: begin
          if (load && beat_q == ddr_pin_pkg::BURST_BEATS) begin
            state_q <= st_idle;
          end
        end
        st_read: begin
          if (rd_count_q == ddr_pin_pkg::BURST_BEATS || rd_wait_q == ddr_pin_pkg::RD_TIMEOUT_CYC) begin
            state_q <= st_idle;
          end
        end
        st_sref: begin
          if (slot && !suspend_req) begin
            state_q <= st_idle;
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  assign init_done = init_done_q;
  assign in_self_refresh = state_q == st_sref;

  // Write words wait here until a write burst drains them
  word_fifo #(.WIDTH(ddr_pin_pkg::WORD_W), .DEPTH(ddr_pin_pkg::FIFO_DEPTH)) wr_fifo (
    .clock(clock),
    .arst_n(arst_n),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data({wr_ecc, wr_data}),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  // Write beats on both command clock halves
  assign load = state_q == st_write && (slot || mid); // RL16
  assign pop = load && fifo_valid && beat_q != ddr_pin_pkg::BURST_BEATS;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      beat_q <= '0;
    end else if (state_q != st_write) begin
      beat_q <= '0;
    end else if (pop) begin
      beat_q <= beat_q + 3'h1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_word_q <= '0;
    end else if (pop) begin
      wr_word_q <= fifo_out; // RL15
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dq_oe_q <= 1'b0;
    end else if (pop) begin
      dq_oe_q <= 1'b1; // RL7
    end else if (load || state_q != st_write) begin
      dq_oe_q <= 1'b0;
    end
  end

  // Strobe toggles a quarter period after each data change
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dqs_q <= 1'b0;
    end else if (state_q != st_write) begin
      dqs_q <= 1'b0;
    end else if (dq_oe_q && (phase_q == ddr_pin_pkg::PH_Q1_END || phase_q == ddr_pin_pkg::PH_Q3_END)) begin
      dqs_q <= ~dqs_q; // RL8
    end
  end

  assign mem_data_lines_o = wr_word_q[ddr_pin_pkg::DATA_W-1:0];
  assign ecc_check_byte_o = wr_word_q[ddr_pin_pkg::WORD_W-1:ddr_pin_pkg::DATA_W];
  assign mem_data_lines_oe = dq_oe_q;
  assign ecc_check_byte_oe = dq_oe_q;
  assign byte_data_strobe_o = {ddr_pin_pkg::LANES{dqs_q}};
  assign byte_data_strobe_oe = {ddr_pin_pkg::LANES{dq_oe_q}};

  // Read capture, each lane on its own strobe
  assign word_done = &got_bus;

  for (genvar i = 0; i < ddr_pin_pkg::LANES; i++) begin : lane
    logic [7:0] pin_byte;
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic e1_q;
    logic got_q;
    logic [7:0] d1_q;
    logic [7:0] d2_q;
    logic [7:0] byte_q;

    if (i < ddr_pin_pkg::LANES - 1) begin : dq
      assign pin_byte = mem_data_lines_i[8*i +: 8]; // RL10
    end else begin : ecc
      assign pin_byte = ecc_check_byte_i; // RL10
    end

    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        d1_q <= '0;
        d2_q <= '0;
      end else begin
        s1_q <= byte_data_strobe_i[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        d1_q <= pin_byte;
        d2_q <= d1_q;
      end
    end

    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        e1_q <= 1'b0;
        byte_q <= '0;
      end else begin
        e1_q <= state_q == st_read && (s2_q ^ s3_q); // RL9 RL16
        if (e1_q) begin
          byte_q <= d2_q; // RL9
        end
      end
    end

    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        got_q <= 1'b0;
      end else if (state_q != st_read) begin
        got_q <= 1'b0;
      end else begin
        got_q <= (got_q && !word_done) || e1_q;
      end
    end

    assign cap_bus[8*i +: 8] = byte_q;
    assign got_bus[i] = got_q;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_count_q <= '0;
      rd_wait_q <= '0;
    end else if (state_q != st_read) begin
      rd_count_q <= '0;
      rd_wait_q <= '0;
    end else begin
      rd_wait_q <= rd_wait_q + 8'h1;
      if (word_done) begin
        rd_count_q <= rd_count_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_valid_q <= 1'b0;
      rd_word_q <= '0;
    end else begin
      rd_valid_q <= word_done;
      if (word_done) begin
        rd_word_q <= cap_bus; // RL15
      end
    end
  end

  assign rd_valid = rd_valid_q;
  assign rd_data = rd_word_q[ddr_pin_pkg::DATA_W-1:0];
  assign rd_ecc = rd_word_q[ddr_pin_pkg::WORD_W-1:ddr_pin_pkg::DATA_W];

  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  clk_pair_a: assert property (cmd_clock_pair_n == ~cmd_clock_pair_p) // RL1
    else $error("clock complement mismatch");
  clk_high_time_a: assert property ($rose(cmd_clock_pair_p[0]) |-> (cmd_clock_pair_p == '1)[*8] ##1 // RL2
    (cmd_clock_pair_p == '0)) else $error("clock pairs not one 64 ns clock");
  select_edge_a: assert property ($changed(row_select_n) |-> $rose(cmd_clock_pair_p[0])) // RL3
    else $error("row select moved off clock rise");
  addr_edge_a: assert property ($changed({mem_addr_mux, bank_select}) |-> $rose(clk_q)) // RL4 RL5
    else $error("address moved off clock rise");
  cmd_qualified_a: assert property ({row_strobe_n, column_strobe_n, write_strobe_n} != ddr_pin_pkg::STB_NOP // RL6
    |-> row_select_n != ddr_pin_pkg::ROWSEL_NONE) else $error("command without row select");
  data_dir_a: assert property (mem_data_lines_oe |-> state_q == st_write && byte_data_strobe_oe == '1) // RL7
    else $error("data driven outside a write");
  wr_centre_a: assert property ($changed(dqs_q) |-> ##1 $stable(wr_word_q)[*3] ##1 $changed(wr_word_q) // RL8
    || !dq_oe_q) else $error("write strobe not centred");
  rd_word_a: assert property (rd_valid |-> $past(got_bus) == '1) // RL9 RL10
    else $error("read word before all lanes");
  init_low_a: assert property (state_q == st_init |-> row_clock_enable == ddr_pin_pkg::CKE_OFF) // RL11
    else $error("clock enable high during init");
  sref_low_a: assert property (state_q == st_sref |-> row_clock_enable == ddr_pin_pkg::CKE_OFF) // RL12
    else $error("clock enable high in self-refresh");
  pdown_mask_a: assert property (state_q == st_idle && slot && !suspend_req // RL13
    |=> row_clock_enable == ~$past(idle_rows)) else $error("idle rows not powered down");
  cke_edge_a: assert property ($changed(row_clock_enable) |-> $rose(cmd_clock_pair_p[0])) // RL14
    else $error("clock enable moved off clock rise");
  ecc_with_data_a: assert property (ecc_check_byte_oe == mem_data_lines_oe) // RL15 RL16
    else $error("check byte not moving with data");
endmodule : ddr_channel_pin_interface

//--- pkg/ddr_pin_pkg.sv
// Constants and types for one DDR channel pin interface.
// Assumes a 250 MHz core clock; all other files use package::name.
package ddr_pin_pkg;

  // Core clock and command clock
  localparam int CLK_NS = 4;
  localparam int CMD_CLK_NS = 64;
  localparam int CMD_DIV = CMD_CLK_NS / CLK_NS;
  localparam logic [3:0] PH_LAST = 4'(CMD_DIV - 1);
  localparam logic [3:0] PH_HALF_END = 4'(CMD_DIV / 2 - 1);
  localparam logic [3:0] PH_Q1_END = 4'(CMD_DIV / 4 - 1);
  localparam logic [3:0] PH_Q3_END = 4'(3 * CMD_DIV / 4 - 1);

  // Power-up hold with clock enables low
  localparam int INIT_HOLD_NS = 200000;
  localparam int INIT_CYC = (INIT_HOLD_NS + CLK_NS - 1) / CLK_NS;

  // Read burst give-up time
  localparam logic [7:0] RD_TIMEOUT_CYC = 8'hff;

  // Widths
  localparam int ROWS = 4;
  localparam int CLK_PAIRS = 6;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int DATA_W = 64;
  localparam int ECC_W = 8;
  localparam int LANES = 9;
  localparam int WORD_W = DATA_W + ECC_W;
  localparam int FIFO_DEPTH = 16;
  localparam logic [2:0] BURST_BEATS = 3'h4;

  // Row selects and clock enables
  localparam logic [3:0] ROWSEL_NONE = 4'hf;
  localparam logic [3:0] CKE_OFF = 4'h0;
  localparam logic [3:0] CKE_ON = 4'hf;

  // Row, column and write strobe levels per command
  localparam logic [2:0] STB_NOP = 3'h7;
  localparam logic [2:0] STB_ACT = 3'h3;
  localparam logic [2:0] STB_RD = 3'h5;
  localparam logic [2:0] STB_WR = 3'h4;
  localparam logic [2:0] STB_PRE = 3'h2;
  localparam logic [2:0] STB_REF = 3'h1;
  localparam logic [2:0] STB_MRS = 3'h0;

  typedef enum logic [2:0] {
    cmd_nop, cmd_activate, cmd_read, cmd_write, cmd_precharge, cmd_refresh, cmd_mode_set
  } cmd_t;

endpackage : ddr_pin_pkg

//--- tb/ddr_mem_model.sv
// Behavioural DDR memory: keeps the last write burst and returns it on reads.
// Assumes the bench resolves the two-way pins and feeds the resolved levels here.
`timescale 1ns/1ns
module ddr_mem_model (
  input wire logic clk_p,
  input wire logic [3:0] row_select_n,
  input wire logic [2:0] stb,
  input wire logic [71:0] bus_w,
  input wire logic strobe_w,
  input wire logic ctrl_oe,
  output logic [71:0] bus_m,
  output logic strobe_m
);
  logic [71:0] mem [4];
  int wi;
  int lag;

  initial begin
    bus_m = '0;
    strobe_m = 1'b0;
    wi = 0;
    lag = 0;
  end

  // Command taken in the high half of the command clock
  always @(negedge clk_p) begin
    if (row_select_n != ddr_pin_pkg::ROWSEL_NONE && stb == ddr_pin_pkg::STB_WR) wi = 0;
    if (row_select_n != ddr_pin_pkg::ROWSEL_NONE && stb == ddr_pin_pkg::STB_RD) begin
      fork
        read_burst();
      join_none
    end
  end

  // Data and strobe change together; released bus shows inverse
  task automatic read_burst();
    #(lag);
    for (int i = 0; i < 4; i++) begin
      bus_m = mem[i];
      strobe_m = ~strobe_m;
      #32;
    end
    bus_m = ~bus_m;
  endtask : read_burst

  // Write beats taken on both strobe edges
  always @(strobe_w) begin
    if (ctrl_oe && wi < 4) begin
      mem[wi] = bus_w;
      wi = wi + 1;
    end
  end
endmodule : ddr_mem_model

//--- tb/tb_top.sv
// Bench for the DDR channel pin interface: commands, FIFO write bursts, reads,
// power-down and self-refresh. Assumes the behavioural memory on the pins.
`timescale 1ns/1ns
module tb_top;
  localparam int INIT = 20;
  logic clock, arst_n, cmd_valid, wr_valid, suspend_req;
  logic cmd_ready, wr_ready, rd_valid, init_done, in_self_refresh, strobe_m;
  logic mem_data_lines_oe, ecc_check_byte_oe, row_strobe_n, column_strobe_n, write_strobe_n;
  ddr_pin_pkg::cmd_t cmd_code;
  logic [1:0] cmd_row, cmd_bank, bank_select;
  logic [12:0] cmd_addr, mem_addr_mux;
  logic [63:0] wr_data, rd_data, mem_data_lines_o;
  logic [7:0] wr_ecc, rd_ecc, ecc_check_byte_o;
  logic [3:0] idle_rows, row_select_n, row_clock_enable;
  logic [5:0] cmd_clock_pair_p, cmd_clock_pair_n;
  logic [8:0] byte_data_strobe_o, byte_data_strobe_oe, dqs_w;
  logic [71:0] bus_m, bus_w;
  int failures, tests_run;

  assign bus_w[63:0] = mem_data_lines_oe ? mem_data_lines_o : bus_m[63:0];
  assign bus_w[71:64] = ecc_check_byte_oe ? ecc_check_byte_o : bus_m[71:64];
  assign dqs_w = (byte_data_strobe_o & byte_data_strobe_oe) | ({9{strobe_m}} & ~byte_data_strobe_oe);

  ddr_channel_pin_interface #(.INIT_CYC(INIT)) u_dut (
    .clock, .arst_n, .cmd_valid, .cmd_ready, .cmd_code, .cmd_row, .cmd_bank, .cmd_addr,
    .wr_valid, .wr_ready, .wr_data, .wr_ecc, .rd_valid, .rd_data, .rd_ecc, .suspend_req,
    .idle_rows, .init_done, .in_self_refresh, .cmd_clock_pair_p, .cmd_clock_pair_n,
    .row_select_n, .mem_addr_mux, .bank_select, .row_strobe_n, .column_strobe_n,
    .write_strobe_n, .row_clock_enable, .mem_data_lines_i(bus_w[63:0]), .mem_data_lines_o,
    .mem_data_lines_oe, .ecc_check_byte_i(bus_w[71:64]), .ecc_check_byte_o,
    .ecc_check_byte_oe, .byte_data_strobe_i(dqs_w), .byte_data_strobe_o, .byte_data_strobe_oe
  );

  ddr_mem_model u_mem (
    .clk_p(cmd_clock_pair_p[0]), .row_select_n, .stb({row_strobe_n, column_strobe_n, write_strobe_n}),
    .bus_w, .strobe_w(dqs_w[0]), .ctrl_oe(mem_data_lines_oe), .bus_m, .strobe_m
  );

  function automatic logic [71:0] word(input int k);
    return {8'he0 + 8'(k), 64'h0f1e2d3c4b5a6978 ^ {8{8'(k)}}};
  endfunction : word

  task automatic close_out();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bound(input int n, input int lim, input string what);
    if (n >= lim) begin
      failures++;
      $display("CHECK FAILED %s expected done seen timeout", what);
      close_out();
    end
  endtask : bound

  task automatic send_cmd(input ddr_pin_pkg::cmd_t c, input logic [1:0] r, input logic [12:0] a,
                          input logic [2:0] stb);
    int n;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_row = r;
    cmd_bank = ~r;
    cmd_addr = a;
    for (n = 0; n < 200 && cmd_ready !== 1'b1; n++) @(negedge clock);
    bound(n, 200, "cmd_ready");
    @(negedge clock);
    cmd_valid = 1'b0;
    chk("row_select_n", 4'(~(4'h1 << r)), row_select_n);
    chk("strobes", stb, {row_strobe_n, column_strobe_n, write_strobe_n});
    chk("mem_addr_mux", a, mem_addr_mux);
    chk("bank_select", 2'(~r), bank_select);
    chk("clock at command", 6'h3f, cmd_clock_pair_p);
  endtask : send_cmd

  task automatic push(input int k, output logic took);
    @(negedge clock);
    wr_valid = 1'b1;
    {wr_ecc, wr_data} = word(k);
    took = wr_ready;
    @(posedge clock);
  endtask : push

  task automatic s_init();
    int n;
    chk("cke in init", 4'h0, row_clock_enable);
    chk("init_done", 1'b0, init_done);
    for (n = 0; n < 16; n++) begin
      @(negedge clock);
      chk("clock complement", 6'(~cmd_clock_pair_p), cmd_clock_pair_n);
      chk("clock pairs alike", {6{cmd_clock_pair_p[0]}}, cmd_clock_pair_p);
    end
    for (n = 0; n < INIT + 40 && row_clock_enable !== 4'hf; n++) @(negedge clock);
    bound(n, INIT + 40, "cke after init");
    chk("init_done", 1'b1, init_done);
    chk("cke on clock rise", 6'h3f, cmd_clock_pair_p);
  endtask : s_init

  task automatic s_cmds();
    send_cmd(ddr_pin_pkg::cmd_activate, 2'h0, 13'h1abc, ddr_pin_pkg::STB_ACT);
    send_cmd(ddr_pin_pkg::cmd_precharge, 2'h1, 13'h0400, ddr_pin_pkg::STB_PRE);
    send_cmd(ddr_pin_pkg::cmd_mode_set, 2'h2, 13'h0123, ddr_pin_pkg::STB_MRS);
    send_cmd(ddr_pin_pkg::cmd_refresh, 2'h3, 13'h1fff, ddr_pin_pkg::STB_REF);
    repeat (16) @(negedge clock);
    chk("strobes idle", ddr_pin_pkg::STB_NOP, {row_strobe_n, column_strobe_n, write_strobe_n});
    chk("selects idle", ddr_pin_pkg::ROWSEL_NONE, row_select_n);
    chk("address held", 13'h1fff, mem_addr_mux);
  endtask : s_cmds

  task automatic s_write();
    logic took;
    int k;
    for (k = 0; k < 17; k++) begin
      push(k, took);
      chk("wr_ready", k < 16, took);
    end
    @(negedge clock);
    wr_valid = 1'b0;
    for (k = 0; k < 4; k++) begin
      send_cmd(ddr_pin_pkg::cmd_write, 2'(k), 13'h0010, ddr_pin_pkg::STB_WR);
      repeat (48) @(negedge clock);
      for (int b = 0; b < 4; b++) chk("write beat", word(4 * k + b), u_mem.mem[b]);
    end
    cmd_valid = 1'b1;
    cmd_code = ddr_pin_pkg::cmd_write;
    for (k = 0; k < 40; k++) begin
      @(negedge clock);
      chk("write with empty fifo", 1'b0, cmd_ready);
    end
    cmd_valid = 1'b0;
  endtask : s_write

  task automatic s_read(input int lag);
    int n;
    int got;
    u_mem.lag = lag;
    send_cmd(ddr_pin_pkg::cmd_read, 2'h1, 13'h0020, ddr_pin_pkg::STB_RD);
    got = 0;
    for (n = 0; n < 250 && got < 4; n++) begin
      @(negedge clock);
      if (rd_valid === 1'b1) begin
        chk("read word", word(12 + got), {rd_ecc, rd_data});
        got++;
      end
    end
    bound(n, 250, "read words");
  endtask : s_read

  task automatic s_pdown();
    int n;
    @(negedge clock);
    idle_rows = 4'h5;
    for (n = 0; n < 40 && row_clock_enable !== 4'ha; n++) @(negedge clock);
    chk("cke power-down", 4'ha, row_clock_enable);
    idle_rows = 4'h0;
    for (n = 0; n < 40 && row_clock_enable !== 4'hf; n++) @(negedge clock);
    chk("cke wake", 4'hf, row_clock_enable);
  endtask : s_pdown

  task automatic s_suspend();
    int n;
    @(negedge clock);
    suspend_req = 1'b1;
    for (n = 0; n < 80 && in_self_refresh !== 1'b1; n++) @(negedge clock);
    bound(n, 80, "self-refresh entry");
    chk("cke in self-refresh", 4'h0, row_clock_enable);
    repeat (40) @(negedge clock);
    chk("cmd_ready in self-refresh", 1'b0, cmd_ready);
    suspend_req = 1'b0;
    for (n = 0; n < 80 && row_clock_enable !== 4'hf; n++) @(negedge clock);
    bound(n, 80, "self-refresh exit");
    chk("in_self_refresh", 1'b0, in_self_refresh);
  endtask : s_suspend

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = ddr_pin_pkg::cmd_nop;
    cmd_row = 2'h0;
    cmd_bank = 2'h0;
    cmd_addr = 13'h0;
    wr_valid = 1'b0;
    wr_data = 64'h0;
    wr_ecc = 8'h0;
    suspend_req = 1'b0;
    idle_rows = 4'h0;
    failures = 0;
    tests_run = 0;
    repeat (16) @(negedge clock);
    arst_n = 1'b1;
    s_init();
    s_cmds();
    s_write();
    s_read(0);
    s_read(200);
    s_pdown();
    s_suspend();
    close_out();
  end
endmodule : tb_top
